//--- verilog/ptw_core.sv
// Command interpreter of a remote measurement pod: time-outs, totals,
// event capture and status, two watchdogs and scan record format.
// Assumes one 25 MHz clock, pins synchronised here, host writes commands.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - Time-out code 0..5 selects fixed period
// R2 - Time-out code resets to 1, two seconds
// R3 - Codes 4 and 5 only in universal variant
// R4 - Overlong measurement returns period time-out error
// R5 - Host picks time-out at least twice period
// R6 - Clear zeroes total, holds counting until measure
// R7 - Total runs since measure, saturates at max
// R8 - Capture enable command alone starts or stops capture
// R9 - Event and status records go on stream 2
// R10 - Status command inserts record per capture channel
// R11 - Full buffer drops status records, lost unchanged
// R12 - Hardware watchdog enable raises output to 1
// R13 - Hardware expiry drops output and resets device
// R14 - Disable forces 0; reset command keeps watchdogs
// R15 - Software watchdog takes 0 or 1..255 seconds
// R16 - Missed pat drops output without reset
// R17 - Output 1 while either watchdog live
// R18 - Scan format selects float or 9-byte record
// R19 - Record leads with 37, then channel states
// R20 - Control bytes mark non-status channels with 1
// R21 - Out-of-range commands are ignored entirely; here they still pat the hardware watchdog
module ptw_core
  import ptw_pkg::*;
#(
  parameter int unsigned NCH        = 20,
  parameter bit          UNIVERSAL  = 1'b1,
  parameter int unsigned TICK_CYC   = MS_CYCLES,
  parameter int unsigned HW_DOG_MS  = 1000
) (
  input  wire logic            i_ref_clk,
  input  wire logic            i_nrst,
  input  wire logic [7:0]      i_addr,
  input  wire logic [31:0]     i_wdata,
  input  wire logic            i_wr,
  input  wire logic            i_rd,
  output logic [31:0]          o_rdata,
  input  wire logic [NCH-1:0]  i_event_pin,
  input  wire logic [NCH-1:0]  i_capture_mode,
  input  wire logic [NCH-1:0]  i_meas_busy,
  output logic [NCH-1:0]       o_period_timeout,
  input  wire logic            i_ev_buf_full,
  output logic                 o_rec_valid,
  output logic [1:0]           o_rec_stream,
  output logic [39:0]          o_rec_data,
  input  wire logic [31:0]     i_switch_pin,
  input  wire logic [31:0]     i_status_mode,
  input  wire logic            i_scan_req,
  output logic                 o_float_req,
  output logic                 o_byte_valid,
  output logic [1:0]           o_byte_stream,
  output logic [7:0]           o_byte,
  output logic                 o_wdog_out,
  output logic                 o_wdog_owned,
  output logic                 o_self_reset
);
  localparam int unsigned CW = $clog2(NCH + 1);
  localparam int unsigned TW = $clog2(TICK_CYC + 1);

  // Parameter check
  if (NCH < 1 || NCH > 32 || TICK_CYC < 1 || HW_DOG_MS < 1 || HW_DOG_MS > 262143) begin : g_chk
    $error("ptw_core: unsupported parameter value");
  end

  // Command decode from a write to the command register
  logic           cmd_go;
  logic [3:0]     op;
  logic [5:0]     chan;
  logic [7:0]     arg;
  logic           chan_ok;
  logic [CW-1:0]  cidx;
  assign cmd_go  = i_wr && (i_addr == REG_CMD);
  assign op      = i_wdata[CMDF_OP_LSB +: 4];
  assign chan    = i_wdata[CMDF_CHAN_LSB +: 6];
  assign arg     = i_wdata[CMDF_ARG_LSB +: 8];
  assign chan_ok = (chan != 6'h00) && (32'(chan) <= NCH); // R21
  assign cidx    = CW'(chan - 6'h01);

  // Argument checks per command
  logic to_ok;
  logic bit_ok;
  assign to_ok  = (arg <= 8'(TO_CODE_MAX)) && (UNIVERSAL || arg <= 8'(TO_CODE_STD)); // R3 R21
  assign bit_ok = (arg <= 8'h01); // R21

  // Soft resets: reset command and hardware expiry
  logic hw_expire;
  logic dev_rst;
  logic full_rst;
  assign dev_rst  = cmd_go && (op == CMD_RESET);
  assign full_rst = !i_nrst || hw_expire;
  assign o_self_reset = hw_expire; // R13

  // Millisecond tick and time tag
  logic [TW-1:0] tick_reg;
  logic          ms_tick;
  logic [31:0]   tag_reg;
  assign ms_tick = (tick_reg == TW'(TICK_CYC - 1));
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      tick_reg <= '0;
      tag_reg  <= '0;
    end else begin
      tick_reg <= ms_tick ? '0 : tick_reg + TW'(1);
      if (ms_tick) tag_reg <= tag_reg + 32'h1;
    end
  end

  // Pin synchronisers
  logic [NCH-1:0] ev_s1_reg, ev_s2_reg, ev_old_reg;
  logic [31:0]    sw_s1_reg, sw_s2_reg;
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      ev_s1_reg  <= '0;
      ev_s2_reg  <= '0;
      ev_old_reg <= '0;
      sw_s1_reg  <= '0;
      sw_s2_reg  <= '0;
    end else begin
      ev_s1_reg  <= i_event_pin;
      ev_s2_reg  <= ev_s1_reg;
      ev_old_reg <= ev_s2_reg;
      sw_s1_reg  <= i_switch_pin;
      sw_s2_reg  <= sw_s1_reg;
    end
  end

  // Capture enable, moved only by the capture command and resets
  logic cap_en_reg;
  always_ff @(posedge i_ref_clk) begin
    if (full_rst || dev_rst) cap_en_reg <= 1'b0;
    else if (cmd_go && op == CMD_EVCAP && bit_ok) cap_en_reg <= arg[0]; // R8
  end

  // Per-channel time-out, total and capture pending
  logic [2:0]     to_code_reg [NCH];
  logic [23:0]    total_reg   [NCH];
  logic [NCH-1:0] cnt_on_reg;
  logic [NCH-1:0] pend_reg;
  logic [NCH-1:0] pend_clr;
  logic [NCH-1:0] to_hit;
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic        sel;
    logic        edge_seen;
    logic [17:0] lim;
    logic [17:0] tmr_reg;
    logic        fired_reg;
    assign sel       = cmd_go && chan_ok && (cidx == CW'(c));
    assign edge_seen = ev_s2_reg[c] ^ ev_old_reg[c];
    // Time-out code to millisecond limit
    always_comb begin
      case (to_code_reg[c])
        3'h0:    lim = TO_MS_0; // R1
        3'h1:    lim = TO_MS_1;
        3'h2:    lim = TO_MS_2;
        3'h3:    lim = TO_MS_3;
        3'h4:    lim = TO_MS_4;
        3'h5:    lim = TO_MS_5;
        default: lim = TO_MS_1;
      endcase
    end
    // Time-out code store
    always_ff @(posedge i_ref_clk) begin
      if (full_rst || dev_rst) to_code_reg[c] <= TO_CODE_RST; // R2
      else if (sel && op == CMD_TIMEOUT && to_ok) to_code_reg[c] <= arg[2:0]; // R1
    end
    // Measurement timer, one error pulse per overlong measurement
    always_ff @(posedge i_ref_clk) begin
      if (full_rst || dev_rst || !i_meas_busy[c]) begin
        tmr_reg   <= '0;
        fired_reg <= 1'b0;
      end else begin
        if (ms_tick && tmr_reg < lim) tmr_reg <= tmr_reg + 18'h1;
        if (tmr_reg >= lim) fired_reg <= 1'b1;
      end
    end
    assign to_hit[c] = i_meas_busy[c] && (tmr_reg >= lim) && !fired_reg; // R4
    // Event total, cleared only by power-up, hardware expiry or clear command
    always_ff @(posedge i_ref_clk) begin
      if (!i_nrst || hw_expire) begin
        total_reg[c]  <= '0;
        cnt_on_reg[c] <= 1'b0;
      end else if (sel && op == CMD_CLEAR) begin
        total_reg[c]  <= '0; // R6
        cnt_on_reg[c] <= 1'b0; // R6
      end else begin
        if (cmd_go && (op == CMD_MEASURE || op == CMD_TRIGGER)) cnt_on_reg[c] <= 1'b1; // R7
        if (cnt_on_reg[c] && ev_s2_reg[c] && !ev_old_reg[c] && total_reg[c] != TOTAL_MAX)
          total_reg[c] <= total_reg[c] + 24'h1; // R7
      end
    end
    // Capture pending, a new edge wins over the drain
    always_ff @(posedge i_ref_clk) begin
      if (full_rst || dev_rst) pend_reg[c] <= 1'b0;
      else if (cap_en_reg && i_capture_mode[c] && edge_seen) pend_reg[c] <= 1'b1; // R8
      else if (pend_clr[c]) pend_reg[c] <= 1'b0;
    end
  end

  // Error pulses registered
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) o_period_timeout <= '0;
    else o_period_timeout <= to_hit; // R4
  end

  // Status walk over capture channels
  ptw_walk_t      walk_reg;
  logic [CW-1:0]  wch_reg;
  logic           walk_last;
  logic           walk_emit;
  assign walk_last = (wch_reg == CW'(NCH - 1));
  assign walk_emit = (walk_reg == WK_RUN) && i_capture_mode[wch_reg];
  always_ff @(posedge i_ref_clk) begin
    if (full_rst || dev_rst) begin
      walk_reg <= WK_IDLE;
      wch_reg  <= '0;
    end else begin
      case (walk_reg)
        WK_IDLE: begin
          wch_reg <= '0;
          if (cmd_go && op == CMD_EVSTAT) walk_reg <= WK_RUN; // R10
        end
        WK_RUN: begin
          wch_reg <= wch_reg + CW'(1);
          if (walk_last || (walk_emit && i_ev_buf_full)) walk_reg <= WK_IDLE; // R11
        end
        default: walk_reg <= WK_IDLE;
      endcase
    end
  end

  // Lowest pending capture channel
  logic          pend_any;
  logic [CW-1:0] pend_ch;
  always_comb begin
    pend_any = 1'b0;
    pend_ch  = '0;
    pend_clr = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        pend_any = 1'b1;
        pend_ch  = CW'(i);
      end
    end
    if (pend_any && !walk_emit) pend_clr[pend_ch] = 1'b1;
  end

  // Record output and lost count; status drops leave lost alone
  logic [15:0] lost_reg;
  always_ff @(posedge i_ref_clk) begin
    if (full_rst || dev_rst) begin
      o_rec_valid <= 1'b0;
      o_rec_data  <= '0;
      lost_reg    <= '0;
    end else begin
      o_rec_valid <= 1'b0;
      if (walk_emit) begin
        o_rec_valid <= !i_ev_buf_full; // R11
        o_rec_data  <= {1'b1, 1'(cap_en_reg), 5'(wch_reg), ev_s2_reg[wch_reg], tag_reg}; // R10
      end else if (pend_any) begin
        o_rec_valid <= !i_ev_buf_full;
        o_rec_data  <= {1'b0, 1'b1, 5'(pend_ch), ev_s2_reg[pend_ch], tag_reg};
        if (i_ev_buf_full && lost_reg != 16'hffff) lost_reg <= lost_reg + 16'h1;
      end
    end
  end
  assign o_rec_stream = STREAM_EVENT; // R9

  // Hardware watchdog, patted by any command write, refused or not
  logic        hw_en_reg;
  logic [17:0] hw_ms_reg;
  assign hw_expire = hw_en_reg && (hw_ms_reg >= 18'(HW_DOG_MS)); // R13
  always_ff @(posedge i_ref_clk) begin
    if (full_rst) begin
      hw_en_reg <= 1'b0; // R13
      hw_ms_reg <= '0;
    end else if (cmd_go && op == CMD_HWDOG && bit_ok) begin
      hw_en_reg <= arg[0]; // R12
      hw_ms_reg <= '0;
    end else if (cmd_go) begin
      hw_ms_reg <= '0;
    end else if (hw_en_reg && ms_tick) begin
      hw_ms_reg <= hw_ms_reg + 18'h1;
    end
  end

  // Software watchdog in whole seconds
  logic        sw_en_reg;
  logic        sw_dead_reg;
  logic [7:0]  sw_sec_reg;
  logic [9:0]  sw_ms_reg;
  logic [7:0]  sw_lim_reg;
  always_ff @(posedge i_ref_clk) begin
    if (full_rst) begin
      sw_en_reg   <= 1'b0;
      sw_dead_reg <= 1'b0;
      sw_sec_reg  <= '0;
      sw_ms_reg   <= '0;
      sw_lim_reg  <= '0;
    end else if (cmd_go && op == CMD_SWDOG) begin
      sw_en_reg   <= (arg != 8'h00); // R15
      sw_lim_reg  <= arg; // R15
      sw_dead_reg <= 1'b0;
      sw_sec_reg  <= '0;
      sw_ms_reg   <= '0;
    end else if (cmd_go && op == CMD_PAT && sw_en_reg && !sw_dead_reg) begin
      sw_sec_reg <= '0; // R16
      sw_ms_reg  <= '0;
    end else if (sw_en_reg && !sw_dead_reg && ms_tick) begin
      if (sw_ms_reg == 10'(MS_PER_S - 1)) begin
        sw_ms_reg  <= '0;
        sw_sec_reg <= sw_sec_reg + 8'h1;
        if (sw_sec_reg + 8'h1 == sw_lim_reg) sw_dead_reg <= 1'b1; // R16
      end else begin
        sw_ms_reg <= sw_ms_reg + 10'h1;
      end
    end
  end

  // Shared watchdog output; reads 0 once both are disabled or expired
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_wdog_out   <= 1'b0;
      o_wdog_owned <= 1'b0;
    end else begin
      o_wdog_out   <= (hw_en_reg && !hw_expire) || (sw_en_reg && !sw_dead_reg); // R12 R14 R17
      o_wdog_owned <= (hw_en_reg && !hw_expire) || sw_en_reg; // R17
    end
  end

  // Scan format select
  logic fmt_reg;
  always_ff @(posedge i_ref_clk) begin
    if (full_rst || dev_rst) fmt_reg <= 1'b0; // R18
    else if (cmd_go && op == CMD_SCANFMT && bit_ok) fmt_reg <= arg[0]; // R18
  end

  // Compressed record, channel 1 in the top bit
  logic [31:0] st_rev, ctl_rev;
  for (genvar b = 0; b < 32; b++) begin : g_rev
    assign st_rev[31-b]  = sw_s2_reg[b]; // R19
    assign ctl_rev[31-b] = !i_status_mode[b]; // R20
  end

  // Scan serialiser
  ptw_scan_t   scan_reg;
  logic [3:0]  bidx_reg;
  logic [63:0] body_reg;
  always_ff @(posedge i_ref_clk) begin
    if (full_rst || dev_rst) begin
      scan_reg     <= SC_IDLE;
      bidx_reg     <= '0;
      body_reg     <= '0;
      o_float_req  <= 1'b0;
      o_byte_valid <= 1'b0;
      o_byte       <= '0;
    end else begin
      o_float_req  <= 1'b0;
      o_byte_valid <= 1'b0;
      case (scan_reg)
        SC_IDLE: begin
          if (i_scan_req && !fmt_reg) o_float_req <= 1'b1; // R18
          if (i_scan_req && fmt_reg) begin
            scan_reg     <= SC_SEND;
            body_reg     <= {st_rev, ctl_rev};
            o_byte       <= COMP_LEAD; // R19
            o_byte_valid <= 1'b1;
            bidx_reg     <= 4'h1;
          end
        end
        SC_SEND: begin
          o_byte       <= body_reg[63:56]; // R19 R20
          o_byte_valid <= 1'b1;
          body_reg     <= {body_reg[55:0], 8'h00};
          bidx_reg     <= bidx_reg + 4'h1;
          if (bidx_reg == COMP_BYTES - 4'h1) scan_reg <= SC_IDLE;
        end
        default: scan_reg <= SC_IDLE;
      endcase
    end
  end
  assign o_byte_stream = fmt_reg ? STREAM_COMP : STREAM_FLOAT;

  // Channel select for readback
  logic [CW-1:0] rsel_reg;
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) rsel_reg <= '0;
    else if (i_wr && i_addr == REG_SEL && i_wdata < NCH) rsel_reg <= CW'(i_wdata);
  end

  // Read data one cycle after the strobe, zero when idle or unmapped
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst || !i_rd) o_rdata <= '0;
    else begin
      case (i_addr)
        REG_STATUS:  o_rdata <= {25'h0, fmt_reg, walk_reg == WK_RUN, cap_en_reg,
                                 sw_dead_reg, sw_en_reg, hw_en_reg, o_wdog_out};
        REG_SEL:     o_rdata <= 32'(rsel_reg);
        REG_TOTAL:   o_rdata <= {8'h00, total_reg[rsel_reg]};
        REG_TIMEOUT: o_rdata <= {29'h0, to_code_reg[rsel_reg]};
        REG_LOST:    o_rdata <= {16'h0, lost_reg};
        default:     o_rdata <= '0;
      endcase
    end
  end
endmodule : ptw_core
`default_nettype wire

//--- verilog/ptw_pkg.sv
// Package for the pod timing and watchdog command block.
// Holds register offsets, command codes, limits and timing constants.
`default_nettype none
package ptw_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned MS_PER_S   = 1000;
  localparam int unsigned MS_CYCLES  = CLK_HZ / MS_PER_S;
  // Time-out periods in milliseconds, codes 0 to 5
  localparam logic [17:0] TO_MS_0 = 18'd200;
  localparam logic [17:0] TO_MS_1 = 18'd2000;
  localparam logic [17:0] TO_MS_2 = 18'd20000;
  localparam logic [17:0] TO_MS_3 = 18'd50000;
  localparam logic [17:0] TO_MS_4 = 18'd70000;
  localparam logic [17:0] TO_MS_5 = 18'd130000;
  localparam logic [2:0]  TO_CODE_RST  = 3'h1;
  localparam logic [2:0]  TO_CODE_STD  = 3'h3;
  localparam logic [2:0]  TO_CODE_MAX  = 3'h5;
  localparam logic [23:0] TOTAL_MAX    = 24'hffffff;
  // Command codes
  localparam logic [3:0] CMD_TIMEOUT = 4'h0;
  localparam logic [3:0] CMD_CLEAR   = 4'h1;
  localparam logic [3:0] CMD_EVCAP   = 4'h2;
  localparam logic [3:0] CMD_EVSTAT  = 4'h3;
  localparam logic [3:0] CMD_HWDOG   = 4'h4;
  localparam logic [3:0] CMD_SWDOG   = 4'h5;
  localparam logic [3:0] CMD_PAT     = 4'h6;
  localparam logic [3:0] CMD_SCANFMT = 4'h7;
  localparam logic [3:0] CMD_RESET   = 4'h8;
  localparam logic [3:0] CMD_MEASURE = 4'h9;
  localparam logic [3:0] CMD_TRIGGER = 4'ha;
  localparam logic [3:0] CMD_ARM     = 4'hb;
  // Command word fields
  localparam int unsigned CMDF_ARG_LSB  = 0;
  localparam int unsigned CMDF_CHAN_LSB = 8;
  localparam int unsigned CMDF_OP_LSB   = 16;
  // Register offsets
  localparam logic [7:0] REG_CMD     = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_SEL     = 8'h08;
  localparam logic [7:0] REG_TOTAL   = 8'h0c;
  localparam logic [7:0] REG_TIMEOUT = 8'h10;
  localparam logic [7:0] REG_LOST    = 8'h14;
  // Streams and record constants
  localparam logic [1:0] STREAM_FLOAT = 2'h0;
  localparam logic [1:0] STREAM_EVENT = 2'h2;
  localparam logic [1:0] STREAM_COMP  = 2'h3;
  localparam logic [7:0] COMP_LEAD    = 8'h25;
  localparam logic [3:0] COMP_BYTES   = 4'h9;
  // Walk and scan states
  typedef enum logic [1:0] {WK_IDLE = 2'b00, WK_RUN = 2'b01} ptw_walk_t;
  typedef enum logic [1:0] {SC_IDLE = 2'b00, SC_SEND = 2'b01} ptw_scan_t;
endpackage : ptw_pkg
`default_nettype wire

//--- verif/ptw_props.sv
// Port checker for ptw_core, bound onto every instance.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ptw_props
  import ptw_pkg::*;
#(
  parameter int unsigned NCH = 20
) (
  input wire logic           i_ref_clk,
  input wire logic           i_nrst,
  input wire logic [7:0]     i_addr,
  input wire logic [31:0]    i_wdata,
  input wire logic           i_wr,
  input wire logic [NCH-1:0] i_meas_busy,
  input wire logic [NCH-1:0] o_period_timeout,
  input wire logic           i_ev_buf_full,
  input wire logic           o_rec_valid,
  input wire logic [1:0]     o_rec_stream,
  input wire logic           i_scan_req,
  input wire logic           o_float_req,
  input wire logic           o_byte_valid,
  input wire logic [1:0]     o_byte_stream,
  input wire logic [7:0]     o_byte,
  input wire logic           o_wdog_out,
  input wire logic           o_wdog_owned,
  input wire logic           o_self_reset
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);
  // Hardware watchdog enable written
  wire logic hw_on = i_wr && i_addr == REG_CMD && i_wdata[19:16] == CMD_HWDOG
                     && i_wdata[7:0] == 8'h01;
  chk_rec_stream: assert property (o_rec_valid |-> o_rec_stream == STREAM_EVENT)
    else $error("record not on event stream");
  chk_full_drop: assert property ($past(i_ev_buf_full) |-> !o_rec_valid)
    else $error("record written into full buffer");
  chk_timeout_busy: assert property (|o_period_timeout |->
    (o_period_timeout & ~$past(i_meas_busy)) == '0)
    else $error("time-out pulse on idle channel");
  chk_lead_byte: assert property ($rose(o_byte_valid) |->
    o_byte == COMP_LEAD && o_byte_stream == STREAM_COMP)
    else $error("record lead byte wrong");
  chk_nine_bytes: assert property ($rose(o_byte_valid) |-> o_byte_valid[*8] ##1 o_byte_valid)
    else $error("compressed record shorter than nine bytes");
  chk_float_req: assert property (i_scan_req && o_byte_stream == STREAM_FLOAT |=> o_float_req)
    else $error("float scan not requested");
  chk_hw_raise: assert property (hw_on |-> ##[1:2] o_wdog_out)
    else $error("watchdog output not raised");
  chk_expiry_low: assert property (o_self_reset |-> ##[1:2] !o_wdog_out)
    else $error("watchdog output high after expiry");
  chk_out_owned: assert property (o_wdog_out |-> o_wdog_owned)
    else $error("watchdog output high while released");
  // Main scenarios reached
  cover property (o_rec_valid && i_ev_buf_full);
  cover property ($rose(o_byte_valid));
  cover property (o_self_reset);
endmodule : ptw_props
bind ptw_core ptw_props #(.NCH(NCH)) ptw_props_i (.i_ref_clk, .i_nrst, .i_addr, .i_wdata,
  .i_wr, .i_meas_busy, .o_period_timeout, .i_ev_buf_full, .o_rec_valid, .o_rec_stream,
  .i_scan_req, .o_float_req, .o_byte_valid, .o_byte_stream, .o_byte, .o_wdog_out,
  .o_wdog_owned, .o_self_reset);
`default_nettype wire

//--- verif/ptw_evbuf_model.sv
// Event buffer model on the far side of the record port.
// Assumes one-cycle record pulses; drain empties it at once.
`timescale 1ns/1ps
`default_nettype none
module ptw_evbuf_model #(
  parameter int unsigned DEPTH = 4
) (
  input  wire logic i_ref_clk,
  input  wire logic i_nrst,
  input  wire logic i_rec_valid,
  input  wire logic i_drain,
  output logic      o_full,
  output logic [7:0] o_count
);
  // Full counts the record arriving now, as a real buffer would
  assign o_full = (o_count + 8'(i_rec_valid)) >= DEPTH;
  // Stored record count
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst || i_drain) o_count <= 8'h0;
    else if (i_rec_valid && o_count < DEPTH) o_count <= o_count + 8'h1;
  end
endmodule : ptw_evbuf_model
`default_nettype wire

//--- verif/ptw_core_bench.sv
// Self-checking bench for ptw_core with an event buffer model.
// Assumes a short time base: TICK_CYC 5 and HW_DOG_MS 3.
`timescale 1ns/1ps
`default_nettype none
module ptw_core_bench
  import ptw_pkg::*;
;
  localparam int TK = 5;
  logic          i_ref_clk, i_nrst, i_wr, i_rd, i_scan_req, i_ev_buf_full, drain;
  logic          o_rec_valid, o_float_req, o_byte_valid, o_wdog_out, o_wdog_owned, o_self_reset;
  logic [1:0]    o_rec_stream, o_byte_stream;
  logic [7:0]    i_addr, o_byte, nrec;
  logic [31:0]   i_wdata, o_rdata, i_switch_pin, i_status_mode, rd, seed, m;
  logic [39:0]   o_rec_data;
  logic [71:0]   e;
  logic [19:0]   i_event_pin, i_capture_mode, i_meas_busy, o_period_timeout;
  int            err_count, checks, n, k;
  ptw_core #(.NCH(20), .UNIVERSAL(1'b1), .TICK_CYC(TK), .HW_DOG_MS(3)) ptw_core_i (
    .i_ref_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_event_pin,
    .i_capture_mode, .i_meas_busy, .o_period_timeout, .i_ev_buf_full, .o_rec_valid,
    .o_rec_stream, .o_rec_data, .i_switch_pin, .i_status_mode, .i_scan_req, .o_float_req,
    .o_byte_valid, .o_byte_stream, .o_byte, .o_wdog_out, .o_wdog_owned, .o_self_reset);
  ptw_evbuf_model #(.DEPTH(4)) ptw_evbuf_model_i (.i_ref_clk, .i_nrst,
    .i_rec_valid(o_rec_valid), .i_drain(drain), .o_full(i_ev_buf_full), .o_count(nrec));
  // Clock at 25 MHz
  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  function automatic logic [31:0] rev(input logic [31:0] x);
    for (int i = 0; i < 32; i++) rev[i] = x[31 - i];
  endfunction : rev
  task automatic final_report();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [39:0] x, input logic [39:0] s);
    checks++;
    if (s !== x) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  // Bounded wait: 0 time-out pulse, 1 self reset, 2 output low
  task automatic wt(input int sel, input int lim);
    n = 0;
    while ((sel == 0 ? o_period_timeout[0] : sel == 1 ? o_self_reset : !o_wdog_out) !== 1'b1) begin
      @(posedge i_ref_clk);
      n++;
      if (n > lim) chk("wait_bound", 40'h1, 40'h0);
      if (n > lim) final_report();
    end
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_ref_clk);
    i_wr    <= 1'b0;
    @(posedge i_ref_clk);
  endtask : wr
  task automatic cmd(input logic [3:0] op, input logic [5:0] ch, input logic [7:0] arg);
    wr(REG_CMD, {12'h0, op, 2'b0, ch, arg});
  endtask : cmd
  task automatic rc(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] x);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_ref_clk);
    i_rd   <= 1'b0;
    #1 rd = o_rdata;
    chk("read", {8'h0, x}, {8'h0, rd & msk});
    @(posedge i_ref_clk);
  endtask : rc
  task automatic tcode(input logic [5:0] ch, input logic [2:0] x);
    wr(REG_SEL, {26'h0, ch - 6'h1});
    rc(REG_TIMEOUT, 32'h7, {29'h0, x});
  endtask : tcode
  task automatic pulse(input int p, input int c);
    repeat (c) begin
      i_event_pin[p] <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      i_event_pin[p] <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
    end
  endtask : pulse
  initial begin
    {i_nrst, i_wr, i_rd, i_scan_req, drain, i_addr, i_wdata} = '0;
    {i_event_pin, i_capture_mode, i_meas_busy, i_switch_pin, i_status_mode} = '0;
    {err_count, checks} = '0;
    seed = 32'hd8b90e88;
    repeat (20) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    @(posedge i_ref_clk);
    // Reset values, unmapped read
    tcode(6'd20, TO_CODE_RST);
    rc(REG_STATUS, 32'h7f, 32'h0);
    rc(8'h18, 32'hffffffff, 32'h0);
    // Every code on a random channel, then refused writes
    seed = xs(seed);
    k = 1 + seed % 20;
    for (int c = 0; c < 6; c++) begin
      cmd(CMD_TIMEOUT, 6'(k), 8'(c));
      tcode(6'(k), 3'(c));
    end
    cmd(CMD_TIMEOUT, 6'(k), 8'h6);
    cmd(CMD_TIMEOUT, 6'd0, 8'h0);
    tcode(6'(k), TO_CODE_MAX);
    // Code 0 on channel 1: 200 ms time-out pulse, wait bound 1200 cycles
    cmd(CMD_TIMEOUT, 6'd1, 8'h0);
    i_meas_busy <= 20'h1;
    wt(0, 1200);
    chk("period_timeout", 40'h1, 40'(n > 200 * TK - 8 && n < 200 * TK + 8));
    i_meas_busy <= 20'h0;
    // Totals: none before measure, counted after, cleared and held
    seed = xs(seed);
    wr(REG_SEL, 32'h4);
    pulse(4, 2);
    rc(REG_TOTAL, 32'hffffff, 32'h0);
    cmd(CMD_MEASURE, 6'd5, 8'h0);
    pulse(4, 1 + seed % 7);
    rc(REG_TOTAL, 32'hffffff, 1 + seed % 7);
    cmd(CMD_CLEAR, 6'd5, 8'h0);
    pulse(4, 2);
    rc(REG_TOTAL, 32'hffffff, 32'h0);
    cmd(CMD_TRIGGER, 6'd5, 8'h0);
    pulse(4, 1);
    rc(REG_TOTAL, 32'hffffff, 32'h1);
    // Capture enable unaffected by measure and arm
    i_capture_mode <= 20'h1;
    cmd(CMD_EVCAP, 6'd0, 8'h1);
    cmd(CMD_MEASURE, 6'd1, 8'h0);
    cmd(CMD_ARM, 6'd1, 8'h0);
    rc(REG_STATUS, 32'h10, 32'h10);
    pulse(0, 1);
    chk("capture_rec", 40'h1, 40'(nrec != 8'h0));
    cmd(CMD_EVCAP, 6'd0, 8'h0);
    drain <= 1'b1;
    @(posedge i_ref_clk);
    drain <= 1'b0;
    pulse(0, 1);
    chk("capture_off", 40'h0, 40'(nrec));
    // Status insert, partial and overflowing the buffer
    seed = xs(seed);
    for (int t = 0; t < 2; t++) begin
      i_capture_mode <= t == 0 ? 20'(seed) & 20'h00421 : 20'hfffff;
      drain <= 1'b1;
      @(posedge i_ref_clk);
      drain <= 1'b0;
      cmd(CMD_EVSTAT, 6'd0, 8'h0);
      repeat (24) @(posedge i_ref_clk);
      n = $countones(i_capture_mode);
      chk("status_recs", 40'(n < 4 ? n : 4), 40'(nrec));
      // Fifth status record is the one dropped: channel 5, capture off, pin low
      if (t == 1) chk("rec_head", 40'h88, 40'(o_rec_data[39:32]));
    end
    rc(REG_LOST, 32'hffffffff, 32'h0);
    // Compressed scan record, refused format, float scan
    seed = xs(seed);
    i_switch_pin  <= seed;
    i_status_mode <= xs(seed);
    cmd(CMD_SCANFMT, 6'd0, 8'h1);
    cmd(CMD_SCANFMT, 6'd0, 8'h2);
    rc(REG_STATUS, 32'h40, 32'h40);
    e = {COMP_LEAD, rev(seed), rev(~xs(seed))};
    i_scan_req <= 1'b1;
    @(posedge i_ref_clk);
    i_scan_req <= 1'b0;
    for (int j = 0; j < 9; j++) begin
      #1 chk("scan_byte", {31'h1, e[71 - 8 * j -: 8]}, {31'(o_byte_valid), o_byte});
      @(posedge i_ref_clk);
    end
    cmd(CMD_SCANFMT, 6'd0, 8'h0);
    i_scan_req <= 1'b1;
    @(posedge i_ref_clk);
    i_scan_req <= 1'b0;
    #1 chk("float_req", 40'h2, {38'h0, o_float_req, o_byte_valid});
    @(posedge i_ref_clk);
    // Hardware watchdog: enable, pats, expiry resets settings
    cmd(CMD_TIMEOUT, 6'd3, 8'h2);
    cmd(CMD_HWDOG, 6'd0, 8'h1);
    rc(REG_STATUS, 32'h3, 32'h3);
    repeat (6) cmd(CMD_ARM, 6'd1, 8'h0);
    wt(1, 40);
    chk("hw_expiry", 40'h1, 40'(n >= 3 * TK - 2 * TK && n <= 3 * TK + 3));
    repeat (2) @(posedge i_ref_clk);
    rc(REG_STATUS, 32'h3, 32'h0);
    tcode(6'd3, TO_CODE_RST);
    cmd(CMD_HWDOG, 6'd0, 8'h1);
    cmd(CMD_HWDOG, 6'd0, 8'h0);
    rc(REG_STATUS, 32'h3, 32'h0);
    // Software watchdog: host pats in time, then misses one
    cmd(CMD_TIMEOUT, 6'd3, 8'h4);
    cmd(CMD_SWDOG, 6'd0, 8'h1);
    rc(REG_STATUS, 32'h5, 32'h5);
    repeat (7) begin
      repeat (800) @(posedge i_ref_clk);
      cmd(CMD_PAT, 6'd0, 8'h0);
    end
    rc(REG_STATUS, 32'h1, 32'h1);
    wt(2, 6000);
    chk("sw_expiry", 40'h1, 40'(n > 1000 * TK - 12 && n < 1000 * TK + 8));
    rc(REG_STATUS, 32'hf, 32'hc);
    tcode(6'd3, 3'h4);
    // Reset command keeps watchdogs; output follows either one
    cmd(CMD_SWDOG, 6'd0, 8'hff);
    cmd(CMD_RESET, 6'd0, 8'h0);
    rc(REG_STATUS, 32'h5, 32'h5);
    cmd(CMD_HWDOG, 6'd0, 8'h1);
    cmd(CMD_SWDOG, 6'd0, 8'h0);
    rc(REG_STATUS, 32'h7, 32'h3);
    cmd(CMD_HWDOG, 6'd0, 8'h0);
    rc(REG_STATUS, 32'h7, 32'h0);
    chk("owned", 40'h0, 40'(o_wdog_owned));
    final_report();
  end
endmodule : ptw_core_bench
`default_nettype wire
